// File: dv/scrtc_remote.sv
// remote serial node facing the core's line pins
`timescale 1ns/1ps
module scrtc_remote (
   input wire logic clk,   // system clock
   input wire logic txd,   // core transmit line
   input wire logic tbclk, // core bit clock
   input wire logic sclk,  // core shift clock
   output logic     rxd,   // core receive line
   output logic     cts,   // clear to send
   output logic     eclk   // external shift clock
);
   initial
   begin
      rxd = 1'b1;
      cts = 1'b0;
      eclk = 1'b0;
   end
   // external shift clock partner: idle level fe, active edge is the other way
   task automatic eshift(input logic fe, input logic [7:0] d, output logic [7:0] q);
      eclk <= fe;
      for (int i = 0; i < 8; i++)
      begin
         rxd <= d[i];
         repeat (5) @(posedge clk);
         eclk <= ~fe;
         repeat (5) @(posedge clk);
         q[i] = txd;
         eclk <= fe;
      end
      rxd <= 1'b1;
   endtask
   // one frame, lsb first, 16 ticks a bit
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++)
      begin
         rxd <= f[i];
         repeat (16) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic glitch();
      rxd <= 1'b0;
      repeat (3) @(posedge clk);
      rxd <= 1'b1;
      repeat (40) @(posedge clk);
   endtask
   // sample at bit centres; ph is the bit clock at the start edge
   task automatic grab(input int n, output logic [10:0] f, output logic ph);
      f = '0;
      @(negedge txd);
      #1 ph = tbclk;
      repeat (8) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         f[i] = txd;
         repeat (16) @(posedge clk);
      end
   endtask
   // shift register partner: new input bit after each falling clock
   task automatic shift(input logic [7:0] d, output logic [7:0] q);
      rxd <= d[0];
      for (int i = 0; i < 8; i++)
      begin
         @(negedge sclk);
         q[i] = txd;
         rxd <= (i < 7) ? d[(i + 1) % 8] : 1'b1;
      end
   endtask
endmodule // scrtc_remote

// File: dv/scrtc_sva.sv
// port checker of the serial core
`timescale 1ns/1ps
module scrtc_sva (
   input wire logic        clk,                   // clock
   input wire logic        nrst,                  // reset, low
   input wire logic        hsel,                  // ahb select
   input wire logic [1:0]  htrans,                // ahb transfer
   input wire logic        hwrite,                // ahb write
   input wire logic        hreadyout,             // ahb ready
   input wire logic        hresp,                 // ahb response
   input wire logic [31:0] hrdata,                // ahb read data
   input wire logic        transmit_line,         // serial out
   input wire logic        shift_clock_oe,        // clock drive
   input wire logic        transmit_interrupt,    // tx empty
   input wire logic        transmit_shift_strobe, // bit pulse
   input wire logic        transmit_bit_clock     // bit clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave stalled or not okay");
   rdata_hold_a: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   tbclk_high_a: assert property ($rose(transmit_bit_clock) |=> transmit_bit_clock [*7])
      else $error("bit clock high phase short");
   tbclk_low_a: assert property ($fell(transmit_bit_clock) |=> !transmit_bit_clock [*7])
      else $error("bit clock low phase short");
   strobe_gap_a: assert property (transmit_shift_strobe && !shift_clock_oe
      |=> !transmit_shift_strobe [*7])
      else $error("bit strobes too close");
   line_strobe_a: assert property (!shift_clock_oe && $changed(transmit_line)
      |-> transmit_shift_strobe)
      else $error("line changed without strobe");
   txint_last_a: assert property (transmit_interrupt && !shift_clock_oe
      |-> transmit_line && transmit_shift_strobe)
      else $error("tx interrupt not at final bit");
endmodule // scrtc_sva

bind scrtc_core scrtc_sva i_scrtc_sva (.clk(clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .transmit_line(transmit_line), .shift_clock_oe(shift_clock_oe),
   .transmit_interrupt(transmit_interrupt), .transmit_shift_strobe(transmit_shift_strobe),
   .transmit_bit_clock(transmit_bit_clock));

// File: dv/tb.sv
// self-checking testbench of the serial core
`timescale 1ns/1ps
`include "scrtc_cfg.svh"
module tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        brg_tick = 1'b0;
   logic        hreadyout, hresp, txd, sclk, sclk_oe, rxd, cts, rxi, txi, stb, tbclk, eclk;
   logic [31:0] hrdata;
   int          mismatches = 0, cmp_count = 0, cyc = 0, nrx = 0, nfall = 0;
   always #25 clk = ~clk;
   scrtc_core i_scrtc_core (.clk(clk), .nrst(nrst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .brg_tick(brg_tick),
      .sys_tick(1'b1), .timer0_match(1'b0), .receive_line(rxd), .transmit_line(txd),
      .shift_clock_in(eclk), .shift_clock_out(sclk), .shift_clock_oe(sclk_oe),
      .clear_to_send_input(cts), .receive_interrupt(rxi), .transmit_interrupt(txi),
      .transmit_shift_strobe(stb), .transmit_bit_clock(tbclk));
   scrtc_remote i_scrtc_remote (.clk(clk), .txd(txd), .tbclk(tbclk), .sclk(sclk), .rxd(rxd),
      .cts(cts), .eclk(eclk));
   always @(posedge clk)
   begin
      brg_tick <= ~brg_tick;
      cyc <= cyc + 1;
      if (rxi === 1'b1) nrx <= nrx + 1;
      if (cyc == 10000)
      begin
         mismatches = mismatches + 1;
         complete_run();
      end
   end
   always @(negedge txd) nfall = nfall + 1;
   task automatic complete_run();
      if (mismatches == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {28'h0, a, 2'h0};
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [1:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h0, q);
      chk(q, e);
   endtask
   task automatic tx_frame(input logic [7:0] d, input int n, input logic [10:0] e,
      input logic pe);
      logic [10:0] f;
      logic ph;
      fork
         i_scrtc_remote.grab(n, f, ph);
         wr(`SCRTC_A_BUF, d);
      join
      chk({21'h0, f}, {21'h0, e});
      chk({31'h0, ph}, {31'h0, pe});
   endtask
   task automatic s_regs();
      rdc(`SCRTC_A_MOD, 32'h0);
      rdc(`SCRTC_A_CTL, 32'h0);
      wr(`SCRTC_A_CTL, 8'hFF);
      rdc(`SCRTC_A_CTL, 32'h0F);
      wr(`SCRTC_A_STA, 8'hFF);
      rdc(`SCRTC_A_STA, 32'h0);
      wr(`SCRTC_A_CTL, 8'h00);
   endtask
   task automatic s_shift();
      logic [7:0] q;
      fork
         i_scrtc_remote.shift(8'h00, q);
         wr(`SCRTC_A_BUF, 8'hA5);
      join
      chk({24'h0, q}, 32'hA5);
      fork
         i_scrtc_remote.shift(8'h3C, q);
         wr(`SCRTC_A_MOD, 8'h20);
      join
      wr(`SCRTC_A_MOD, 8'h00);
      rdc(`SCRTC_A_BUF, 32'h3C);
   endtask
   task automatic s_ext();
      logic [7:0] q;
      logic [7:0] td;
      logic [7:0] rd;
      for (int e = 0; e < 2; e++)
      begin
         td = e ? 8'hCC : 8'hC3;
         rd = e ? 8'hA5 : 8'h5A;
         wr(`SCRTC_A_CTL, e ? 8'h03 : 8'h02);
         wr(`SCRTC_A_MOD, 8'h20);
         fork
            i_scrtc_remote.eshift(e[0], rd, q);
            wr(`SCRTC_A_BUF, td);
         join
         chk({24'h0, q}, {24'h0, td});
         rdc(`SCRTC_A_BUF, {24'h0, rd});
      end
      wr(`SCRTC_A_MOD, 8'h00);
      wr(`SCRTC_A_CTL, 8'h00);
   endtask
   task automatic s_tx();
      wr(`SCRTC_A_MOD, 8'h06);
      wr(`SCRTC_A_CTL, 8'h0C);
      tx_frame(8'hA5, 11, {1'b1, ^8'hA5, 8'hA5, 1'b0}, 1'b1);
      wr(`SCRTC_A_MOD, 8'h05);
      wr(`SCRTC_A_CTL, 8'h04);
      tx_frame(8'h13, 10, {2'h1, ~^7'h13, 7'h13, 1'b0}, 1'b1);
   endtask
   task automatic s_rx();
      int n0;
      wr(`SCRTC_A_MOD, 8'h26);
      wr(`SCRTC_A_CTL, 8'h0C);
      n0 = nrx;
      i_scrtc_remote.glitch();
      chk(nrx, n0);
      i_scrtc_remote.send({2'h3, 8'h3C, 1'b0}, 11);
      chk(nrx, n0 + 1);
      rdc(`SCRTC_A_CTL, 32'hAC);
      rdc(`SCRTC_A_CTL, 32'h8C);
      rdc(`SCRTC_A_BUF, 32'h3C);
      i_scrtc_remote.send({2'h0, 8'h81, 1'b0}, 11);
      i_scrtc_remote.send({2'h3, 8'h54, 1'b0}, 11);
      rdc(`SCRTC_A_CTL, 32'h5C);
      rdc(`SCRTC_A_BUF, 32'h81);
   endtask
   task automatic s_wake();
      int n0;
      wr(`SCRTC_A_CTL, 8'h00);
      wr(`SCRTC_A_MOD, 8'h37);
      n0 = nrx;
      i_scrtc_remote.send({2'h2, 8'h42, 1'b0}, 11);
      chk(nrx, n0);
      i_scrtc_remote.send({2'h3, 8'h99, 1'b0}, 11);
      chk(nrx, n0 + 1);
      rdc(`SCRTC_A_CTL, 32'h80);
      rdc(`SCRTC_A_BUF, 32'h99);
   endtask
   task automatic s_cts();
      int n0;
      wr(`SCRTC_A_MOD, 8'h46);
      fork
         tx_frame(8'h11, 10, {2'h1, 8'h11, 1'b0}, 1'b1);
         begin
            repeat (60) @(posedge clk);
            i_scrtc_remote.cts <= 1'b1;
         end
      join
      fork
         tx_frame(8'h22, 10, {2'h1, 8'h22, 1'b0}, 1'b0);
         begin
            n0 = nfall;
            repeat (300) @(posedge clk);
            chk(nfall, n0);
            i_scrtc_remote.cts <= 1'b0;
         end
      join
      wr(`SCRTC_A_MOD, 8'h06);
      i_scrtc_remote.cts <= 1'b1;
      tx_frame(8'h33, 10, {2'h1, 8'h33, 1'b0}, 1'b1);
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      s_regs();
      s_shift();
      s_ext();
      s_tx();
      s_rx();
      s_wake();
      s_cts();
      complete_run();
   end
endmodule // tb

// File: rtl/scrtc_cfg.svh
// register map, field positions, codes and timing counts of the serial core
`ifndef SCRTC_CFG_SVH
`define SCRTC_CFG_SVH
// word index of each register (byte address = index * 4)
`define SCRTC_A_BUF   2'h0
`define SCRTC_A_MOD   2'h1
`define SCRTC_A_CTL   2'h2
`define SCRTC_A_STA   2'h3
// mode register fields
`define SCRTC_M_FMT   1:0
`define SCRTC_M_CS    3:2
`define SCRTC_M_WU    4
`define SCRTC_M_RXE   5
`define SCRTC_M_HANDSHAKE_ENABLE  6
`define SCRTC_M_TB8   7
// control register fields
`define SCRTC_C_EDGE  0
`define SCRTC_C_DIR   1
`define SCRTC_C_PE    2
`define SCRTC_C_EVEN  3
`define SCRTC_C_FE    4
`define SCRTC_C_PARITY_ERROR_FLAG  5
`define SCRTC_C_OVERRUN_FLAG  6
`define SCRTC_C_RB8   7
`define SCRTC_C_CFG   3:0
`define SCRTC_C_ERR   6:4
// status register fields
`define SCRTC_S_RFULL 0
`define SCRTC_S_TFULL 1
`define SCRTC_S_TBUSY 2
`define SCRTC_S_RBUSY 3
// reset values
`define SCRTC_MOD_RST 8'h00
`define SCRTC_CTL_RST 8'h00
// frame formats
`define SCRTC_FMT_SH  2'h0
`define SCRTC_FMT_7   2'h1
`define SCRTC_FMT_8   2'h2
`define SCRTC_FMT_9   2'h3
// bit clock sources
`define SCRTC_CS_BRG  2'h0
`define SCRTC_CS_SYS  2'h1
`define SCRTC_CS_TMR  2'h2
// oversampling counts
`define SCRTC_OS_LAST 4'hF
`define SCRTC_OS_MID  4'h7
`define SCRTC_SMP_LO  4'h7
`define SCRTC_SMP_HI  4'h9
`define SCRTC_MAJ_LO  2'h2
// data bit counts
`define SCRTC_NB7     4'h7
`define SCRTC_NB8     4'h8
`define SCRTC_NB9     4'h9
`define SCRTC_SH_LAST 3'h7
`endif

// File: rtl/scrtc_core.sv
// serial channel transmit/receive core with AHB-Lite register slave
//
// Functional notes
// - clock source field picks base clock
// - receiver samples pulses 7,8,9, majority vote
// - internal shift clock: sample on rising edge
// - external shift clock: sample on selected edge
// - start bit needs two of three lows
// - full character copied to buffer, interrupt
// - overrun flags error, drops new character
// - buffer read clears receive request
// - ninth/parity bit stored; wake-up filters interrupts
// - transmit bit clock every 16 pulses
// - internal shift clock: drive on rising edge
// - external shift clock: drive on selected edge
// - transmit starts at next bit clock rise
// - clear-to-send high holds next frame
// - after clear-to-send falls, start on fall
// - LSB first; then empty and interrupt
// - parity only in 7/8-bit formats
// - transmit parity generated from data
// - receive parity mismatch sets error flag
// - stop bit majority low is framing error
// - receive event timing per frame format
// - transmit interrupt as final bit starts
// - format 11 is 9-bit, no parity
// - shift receive only with receive enable
// - control register read clears error flags
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "scrtc_cfg.svh"

module scrtc_core #(
   parameter bit HAS_CTS = 1'b1  // channel has a clear-to-send pin
) (
   input  wire logic        clk,                  // system clock
   input  wire logic        nrst,                 // async reset, low
   input  wire logic        ce,                   // clock enable
   input  wire logic        hsel,                 // ahb select
   input  wire logic [31:0] haddr,                // ahb address
   input  wire logic [1:0]  htrans,               // ahb transfer type
   input  wire logic        hwrite,               // ahb write
   input  wire logic [2:0]  hsize,                // ahb size, word only
   input  wire logic [31:0] hwdata,               // ahb write data
   input  wire logic        hready,               // ahb bus ready
   output logic             hreadyout,            // ahb slave ready
   output logic             hresp,                // ahb response
   output logic [31:0]      hrdata,               // ahb read data
   input  wire logic        brg_tick,             // baud generator pulse
   input  wire logic        sys_tick,             // system-derived pulse
   input  wire logic        timer0_match,         // timer 0 match pulse
   input  wire logic        receive_line,         // serial input
   output logic             transmit_line,        // serial output
   input  wire logic        shift_clock_in,       // shift clock pin in
   output logic             shift_clock_out,      // shift clock pin out
   output logic             shift_clock_oe,       // shift clock drive
   input  wire logic        clear_to_send_input,  // high holds sending
   output logic             receive_interrupt,    // character pulse
   output logic             transmit_interrupt,   // buffer empty pulse
   output logic             transmit_shift_strobe,// per-bit pulse
   output logic             transmit_bit_clock    // 16x divided clock
);

   scrtc_pkg::scrtc_state_type s_q;
   scrtc_pkg::scrtc_state_type s_d;

   logic [1:0] fmt;
   logic       uart;
   logic       pe;
   logic       receive_enable_bit;
   logic       tick;
   logic [3:0] nd;
   logic       at_last;
   logic       ptx;
   logic [8:0] pay;
   logic       hs_hold;
   logic       rise;
   logic       fall;
   logic [3:0] c;
   logic [1:0] zs;
   logic       maj;
   logic       xfer;
   logic       sh_run;
   logic       sh_edge;
   logic       prx;
   logic       a_ph;

   // ==========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      s_d.rxi = 1'b0;
      s_d.txi = 1'b0;
      s_d.stb = 1'b0;
      fmt = s_q.mode[`SCRTC_M_FMT];
      uart = (fmt != `SCRTC_FMT_SH);
      pe = s_q.ctl[`SCRTC_C_PE] & (fmt != `SCRTC_FMT_9);
      receive_enable_bit = s_q.mode[`SCRTC_M_RXE];
      xfer = 1'b0;
      sh_edge = 1'b0;
      prx = 1'b0;
      case (s_q.mode[`SCRTC_M_CS])
         `SCRTC_CS_BRG: tick = brg_tick;
         `SCRTC_CS_SYS: tick = sys_tick;
         `SCRTC_CS_TMR: tick = timer0_match;
         default:       tick = 1'b0;
      endcase
      case (fmt)
         `SCRTC_FMT_7: nd = `SCRTC_NB7 + {3'h0, pe};
         `SCRTC_FMT_8: nd = `SCRTC_NB8 + {3'h0, pe};
         default:      nd = `SCRTC_NB9;
      endcase
      at_last = (fmt == `SCRTC_FMT_9) | ((fmt == `SCRTC_FMT_8) & pe);
      // parity of the written data
      if (fmt == `SCRTC_FMT_7)
         ptx = ~s_q.ctl[`SCRTC_C_EVEN] ^ (^s_q.tbuf[6:0]);
      else
         ptx = ~s_q.ctl[`SCRTC_C_EVEN] ^ (^s_q.tbuf);
      // unused upper payload bits stay high, acting as stop bit
      case (fmt)
         `SCRTC_FMT_7: pay = {1'b1, pe ? ptx : 1'b1, s_q.tbuf[6:0]};
         `SCRTC_FMT_8: pay = {pe ? ptx : 1'b1, s_q.tbuf};
         default:      pay = {s_q.mode[`SCRTC_M_TB8], s_q.tbuf};
      endcase
      hs_hold = HAS_CTS & s_q.mode[`SCRTC_M_HANDSHAKE_ENABLE] & clear_to_send_input;
      rise = tick & (s_q.tcnt == `SCRTC_OS_LAST);
      fall = tick & (s_q.tcnt == `SCRTC_OS_MID);
      c = s_q.rcnt + 4'h1;
      zs = s_q.rzero + {1'b0, ~receive_line};
      maj = (zs < `SCRTC_MAJ_LO);
      sh_run = s_q.tfull | (receive_enable_bit & ~s_q.rfull);
      a_ph = hsel & htrans[1] & hready;

      // ==========================================================
      // bus address phase: reads and their side effects
      s_d.dwr = a_ph & hwrite;
      s_d.dad = haddr[3:2];
      if (a_ph & ~hwrite)
      begin
         s_d.rdata = 32'h0000_0000;
         case (haddr[3:2])
            `SCRTC_A_BUF:
            begin
               s_d.rdata[7:0] = s_q.rbuf;
               s_d.rfull = 1'b0;
            end
            `SCRTC_A_MOD: s_d.rdata[7:0] = s_q.mode;
            `SCRTC_A_CTL:
            begin
               s_d.rdata[7:0] = s_q.ctl;
               s_d.ctl[`SCRTC_C_ERR] = 3'h0;
            end
            `SCRTC_A_STA:
            begin
               s_d.rdata[`SCRTC_S_RFULL] = s_q.rfull;
               s_d.rdata[`SCRTC_S_TFULL] = s_q.tfull;
               s_d.rdata[`SCRTC_S_TBUSY] = s_q.tbusy;
               s_d.rdata[`SCRTC_S_RBUSY] = (s_q.rst != scrtc_pkg::RX_IDLE);
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      // ==========================================================
      // shift mode
      s_d.sprev = shift_clock_in;
      if (!uart)
      begin
         if (!s_q.ctl[`SCRTC_C_DIR])
         begin
            if (brg_tick & (sh_run | s_q.sclk))
               s_d.sclk = ~s_q.sclk;
            sh_edge = brg_tick & sh_run & ~s_q.sclk;
         end
         else if (s_q.ctl[`SCRTC_C_EDGE])
            sh_edge = sh_run & ~shift_clock_in & s_q.sprev;
         else
            sh_edge = sh_run & shift_clock_in & ~s_q.sprev;
         if (sh_edge)
         begin
            s_d.scnt = s_q.scnt + 3'h1;
            if (s_q.tfull)
            begin
               s_d.txd = s_q.tbuf[s_q.scnt];
               s_d.stb = 1'b1;
            end
            if (receive_enable_bit & ~s_q.rfull)
               s_d.rsr[s_q.scnt] = receive_line;
            if (s_q.scnt == `SCRTC_SH_LAST)
            begin
               if (s_q.tfull)
               begin
                  s_d.tfull = 1'b0;
                  s_d.txi = 1'b1;
               end
               if (receive_enable_bit & ~s_q.rfull)
               begin
                  s_d.rbuf = s_d.rsr[7:0];
                  s_d.rfull = 1'b1;
                  s_d.rxi = 1'b1;
               end
            end
         end
      end
      else
      begin
         s_d.sclk = 1'b0;
         s_d.scnt = 3'h0;

         // ==========================================================
         // uart transmitter
         if (tick)
            s_d.tcnt = s_q.tcnt + 4'h1;
         if (s_q.tbusy & tick & (s_q.tcnt == s_q.tph))
         begin
            s_d.stb = 1'b1;
            if (s_q.tleft == 4'h0)
               s_d.tbusy = 1'b0;
            else
            begin
               s_d.txd = s_q.tsr[0];
               s_d.tsr = {1'b1, s_q.tsr[9:1]};
               s_d.tleft = s_q.tleft - 4'h1;
               if (s_q.tleft == 4'h1)
               begin
                  s_d.tfull = 1'b0;
                  s_d.txi = 1'b1;
               end
            end
         end
         else if (!s_q.tbusy & s_q.tfull)
         begin
            if (hs_hold)
               s_d.cwait = 1'b1;
            else if (s_q.cwait ? fall : rise)
            begin
               s_d.tbusy = 1'b1;
               s_d.txd = 1'b0;
               s_d.stb = 1'b1;
               s_d.tsr = {1'b1, pay};
               s_d.tleft = nd + 4'h1;
               s_d.tph = s_q.cwait ? `SCRTC_OS_MID : `SCRTC_OS_LAST;
               s_d.cwait = 1'b0;
            end
         end

         // ==========================================================
         // uart receiver
         if (!receive_enable_bit)
            s_d.rst = scrtc_pkg::RX_IDLE;
         else if (s_q.rst == scrtc_pkg::RX_IDLE)
         begin
            if (tick & ~receive_line)
            begin
               s_d.rst = scrtc_pkg::RX_START;
               s_d.rcnt = 4'h0;
               s_d.rzero = 2'h0;
            end
         end
         else if (tick)
         begin
            s_d.rcnt = c;
            if ((c >= `SCRTC_SMP_LO) & (c <= `SCRTC_SMP_HI))
               s_d.rzero = zs;
            if (c == `SCRTC_SMP_HI)
            begin
               s_d.rzero = 2'h0;
               case (s_q.rst)
                  scrtc_pkg::RX_START:
                  begin
                     s_d.ridx = 4'h0;
                     if (maj)
                        s_d.rst = scrtc_pkg::RX_IDLE;
                     else
                        s_d.rst = scrtc_pkg::RX_BITS;
                  end
                  scrtc_pkg::RX_BITS:
                  begin
                     s_d.rsr[s_q.ridx] = maj;
                     if (s_q.ridx == nd - 4'h1)
                     begin
                        s_d.rst = scrtc_pkg::RX_STOP;
                        xfer = at_last;
                     end
                     else
                        s_d.ridx = s_q.ridx + 4'h1;
                  end
                  scrtc_pkg::RX_STOP:
                  begin
                     if (!maj)
                        s_d.ctl[`SCRTC_C_FE] = 1'b1;
                     xfer = ~at_last;
                     s_d.rst = scrtc_pkg::RX_IDLE;
                  end
                  default: s_d.rst = scrtc_pkg::RX_IDLE;
               endcase
            end
         end

         // character hand-off to the holding buffer
         if (fmt == `SCRTC_FMT_7)
            prx = ~s_q.ctl[`SCRTC_C_EVEN] ^ (^s_d.rsr[6:0]) ^ s_d.rsr[7];
         else
            prx = ~s_q.ctl[`SCRTC_C_EVEN] ^ (^s_d.rsr[7:0]) ^ s_d.rsr[8];
         if (xfer & ~((fmt == `SCRTC_FMT_9) & s_q.mode[`SCRTC_M_WU] & ~s_d.rsr[8]))
         begin
            if (s_d.rfull)
               s_d.ctl[`SCRTC_C_OVERRUN_FLAG] = 1'b1;
            else
            begin
               if ((fmt == `SCRTC_FMT_7) & ~pe)
                  s_d.rbuf = {1'b0, s_d.rsr[6:0]};
               else
                  s_d.rbuf = s_d.rsr[7:0];
               if (at_last)
                  s_d.ctl[`SCRTC_C_RB8] = s_d.rsr[8];
               if (pe & prx)
                  s_d.ctl[`SCRTC_C_PARITY_ERROR_FLAG] = 1'b1;
               s_d.rfull = 1'b1;
               s_d.rxi = 1'b1;
            end
         end
      end

      // ==========================================================
      // bus data phase: writes
      if (s_q.dwr)
      begin
         case (s_q.dad)
            `SCRTC_A_BUF:
            begin
               s_d.tbuf = hwdata[7:0];
               s_d.tfull = 1'b1;
               if (!uart)
                  s_d.scnt = 3'h0;
            end
            `SCRTC_A_MOD: s_d.mode = hwdata[7:0];
            `SCRTC_A_CTL: s_d.ctl[`SCRTC_C_CFG] = hwdata[`SCRTC_C_CFG];
            default: s_d.dwr = s_d.dwr;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '0;
         s_q.mode <= `SCRTC_MOD_RST;
         s_q.ctl <= `SCRTC_CTL_RST;
         s_q.txd <= 1'b1;
         s_q.rst <= scrtc_pkg::RX_IDLE;
      end
      else if (ce)
         s_q <= s_d;
   end

   // ==========================================================
   // outputs
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign transmit_line = s_q.txd;
   assign shift_clock_out = s_q.sclk;
   assign shift_clock_oe = (s_q.mode[`SCRTC_M_FMT] == `SCRTC_FMT_SH) & ~s_q.ctl[`SCRTC_C_DIR];
   assign receive_interrupt = s_q.rxi;
   assign transmit_interrupt = s_q.txi;
   assign transmit_shift_strobe = s_q.stb;
   assign transmit_bit_clock = ~s_q.tcnt[3];

endmodule // scrtc_core

// File: rtl/scrtc_pkg.sv
// types of the serial core
package scrtc_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} scrtc_rx_type;
   typedef struct packed {
      logic [7:0]   mode;
      logic [7:0]   ctl;
      logic [7:0]   rbuf;
      logic         rfull;
      logic [7:0]   tbuf;
      logic         tfull;
      logic         tbusy;
      logic [9:0]   tsr;
      logic [3:0]   tleft;
      logic [3:0]   tph;
      logic [3:0]   tcnt;
      logic         cwait;
      logic         txd;
      scrtc_rx_type rst;
      logic [3:0]   rcnt;
      logic [8:0]   rsr;
      logic [3:0]   ridx;
      logic [1:0]   rzero;
      logic         sclk;
      logic         sprev;
      logic [2:0]   scnt;
      logic         dwr;
      logic [1:0]   dad;
      logic [31:0]  rdata;
      logic         rxi;
      logic         txi;
      logic         stb;
   } scrtc_state_type;
endpackage
